// *** src/sfc_defs.vh ***
// constants for the serial flash command front end
// Functional notes
// - write-enable opcode framed by a complete 8-bit frame sets the latch
// - volatile-write-enable leaves the latch alone, arms next status write as volatile
// - write-disable opcode clears the latch
// - latch clears at power-up, after non-volatile status write, and on reset
// - read-status opcodes shift the chosen status byte out MSB first on falling edges
// - status reads work even while busy and repeat until chip select rises
// - status writes change only the writable bit locations
// - security lock bits and status lock never return from 1 to 0, except when reset or a non-volatile status write loads a 0 from the non-volatile copy
// - non-volatile status write needs the latch set, opcode plus data in one frame
// - non-volatile write runs a timed busy cycle, then clears busy and latch
// - volatile status write updates at frame end, busy stays 0 and the latch keeps its value
// - reset discards volatile status values and reloads the non-volatile copies
// - legacy write with 16 data bits updates registers 1 and 2, 8 bits only 1
// - read-extended-address opcode shifts the upper address byte out MSB first
// - 3-byte mode takes address bits 31..24 from the upper address byte
// - upper address byte write accepted only with the latch set
// - upper address byte clears at power-up and on reset
// - in 4-byte mode the top address byte of a command loads the register
// - enter and exit opcodes switch between 32-bit and 24-bit addressing
// - read data takes opcode and address, streams bytes MSB first, auto-increment
// - read data received while busy is ignored
// - every byte on the serial link moves MSB first
`ifndef SFC_DEFS_VH
`define SFC_DEFS_VH

`define SFC_OP_WREN       8'h06
`define SFC_OP_WRDI       8'h04
`define SFC_OP_VWREN      8'h50
`define SFC_OP_RDSR1      8'h05
`define SFC_OP_RDSR2      8'h35
`define SFC_OP_RDSR3      8'h15
`define SFC_OP_WRSR1      8'h01
`define SFC_OP_WRSR2      8'h31
`define SFC_OP_WRSR3      8'h11
`define SFC_OP_RDEAR      8'hC8
`define SFC_OP_WREAR      8'hC5
`define SFC_OP_EN4B       8'hB7
`define SFC_OP_EX4B       8'hE9
`define SFC_OP_READ       8'h03

// writable and one-time-programmable bit masks per status register
`define SFC_SR1_WR_MASK   8'h7C
`define SFC_SR1_OTP_MASK  8'h00
`define SFC_SR2_WR_MASK   8'h7B
`define SFC_SR2_OTP_MASK  8'h39
`define SFC_SR3_WR_MASK   8'h66
`define SFC_SR3_OTP_MASK  8'h00
`define SFC_SR1_INIT      8'h00
`define SFC_SR2_INIT      8'h00
`define SFC_SR3_INIT      8'h00
`define SFC_SR1_BUSY_BIT  0
`define SFC_SR1_WEL_BIT   1
`define SFC_SR3_ADS_BIT   0
`define SFC_SR3_ADP_BIT   1
`define SFC_EXT_INIT      8'h00

`define SFC_CLK_PERIOD_NS        5
`define SFC_STATUS_WRITE_TIME_NS 10000
`define SFC_LAST_BIT      3'h7
`define SFC_ADDR3_LAST    3'h2
`define SFC_ADDR4_LAST    3'h3

`endif

// *** src/sfc_buf2.v ***
// two-entry elastic buffer between memory stream and serial shifter
`timescale 1ns/10ps
module sfc_buf2 #(
   parameter WIDTH = 8
) (
   input  wire             sys_clk_i,
   input  wire             nrst_i,
   input  wire             flush_i,
   input  wire             in_valid_i,
   output reg              in_ready_o,
   input  wire [WIDTH-1:0] in_data_i,
   output wire             out_valid_o,
   input  wire             out_ready_i,
   output wire [WIDTH-1:0] out_data_o
);
   reg  [WIDTH-1:0] slot0;
   reg  [WIDTH-1:0] slot1;
   reg  [1:0]       count;
   reg  [1:0]       next_count;
   wire             push;
   wire             pop;

   assign out_valid_o = (count != 2'h0);
   assign out_data_o  = slot0;
   assign push        = in_valid_i & in_ready_o;
   assign pop         = out_ready_i & out_valid_o;

   always @* begin
      next_count = count;
      if (flush_i) begin
         next_count = 2'h0;
      end else if (push & ~pop) begin
         next_count = count + 2'h1;
      end else if (pop & ~push) begin
         next_count = count - 2'h1;
      end
   end

   always @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         count      <= 2'h0;
         in_ready_o <= 1'b0;
         slot0      <= {WIDTH{1'b0}};
         slot1      <= {WIDTH{1'b0}};
      end else begin
         count      <= next_count;
         // registered ready from next count: full shows in the same cycle, never overruns
         in_ready_o <= (next_count != 2'h2);
         if (pop) begin
            slot0 <= (count == 2'h2) ? slot1 : in_data_i;
            slot1 <= in_data_i;
         end else if (push) begin
            if (count == 2'h0) begin
               slot0 <= in_data_i;
            end else begin
               slot1 <= in_data_i;
            end
         end
      end
   end
endmodule // sfc_buf2

// *** src/sfc_stat_byte.v ***
// one status register with volatile and non-volatile copies
`timescale 1ns/10ps
`include "sfc_defs.vh"
module sfc_stat_byte #(
   parameter [7:0] WR_MASK  = 8'h00,
   parameter [7:0] OTP_MASK = 8'h00,
   parameter [7:0] NV_INIT  = 8'h00
) (
   input  wire       sys_clk_i,
   input  wire       nrst_i,
   input  wire       reload_i,
   input  wire       wr_vol_i,
   input  wire       wr_nv_i,
   input  wire [7:0] data_i,
   output reg  [7:0] value_o,
   output reg  [7:0] stored_o
);
   wire [7:0] vol_new;
   wire [7:0] nv_new;

   assign vol_new = (value_o & ~WR_MASK) | (data_i & WR_MASK)
                  | (value_o & OTP_MASK);
   assign nv_new  = (stored_o & ~WR_MASK) | (data_i & WR_MASK)
                  | (stored_o & OTP_MASK);

   always @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         value_o  <= NV_INIT;
         stored_o <= NV_INIT;
      end else if (reload_i) begin
         value_o  <= stored_o;
      end else if (wr_nv_i) begin
         stored_o <= nv_new;
         value_o  <= nv_new;
      end else if (wr_vol_i) begin
         value_o  <= vol_new;
      end
   end
endmodule // sfc_stat_byte

// *** src/sfc_frontend.v ***
// serial flash command front end: opcode decode, status, address, read
`timescale 1ns/10ps
`include "sfc_defs.vh"
module sfc_frontend #(
   parameter TW_NS     = `SFC_STATUS_WRITE_TIME_NS,
   parameter TW_CYCLES = TW_NS / `SFC_CLK_PERIOD_NS
) (
   input  wire        sys_clk_i,
   input  wire        nrst_i,
   input  wire        hw_reset_i,
   input  wire        cs_n_i,
   input  wire        spi_clk_i,
   input  wire        serial_in_i,
   output reg         serial_out_o,
   output reg         serial_out_oe_n_o,
   output reg         mem_req_o,
   output reg  [31:0] mem_addr_o,
   input  wire [7:0]  mem_data_i,
   input  wire        mem_valid_i,
   output wire        mem_ready_o,
   output reg         write_enable_latch_o,
   output reg         busy_o,
   output reg         addr_width_state_o,
   output reg  [7:0]  upper_address_byte_o
);
   localparam ST_OPC  = 3'h0;
   localparam ST_DONE = 3'h1;
   localparam ST_ADDR = 3'h2;
   localparam ST_WDAT = 3'h3;
   localparam ST_OUT  = 3'h4;
   localparam ST_RDAT = 3'h5;
   localparam ST_IGN  = 3'h6;
   localparam [7:0] SR3_INIT = `SFC_SR3_INIT;
   reg  [2:0]  state;
   reg         sclk_q;
   reg         cs_q;
   reg  [7:0]  sh_in;
   reg  [2:0]  bit_cnt;
   reg  [2:0]  byte_cnt;
   reg  [7:0]  opcode;
   reg  [23:0] addr_lo;
   reg  [7:0]  wd1;
   reg  [7:0]  wd2;
   reg         vol_armed;
   reg  [15:0] tw_cnt;
   reg  [7:0]  p1;
   reg  [7:0]  p2;
   reg  [2:0]  pend_sel;
   reg  [2:0]  commit_vol;
   reg  [2:0]  commit_nv;
   reg  [7:0]  osh;
   reg  [2:0]  ocnt;
   reg  [7:0]  out_byte;
   wire        sclk_rise;
   wire        sclk_fall;
   wire        cs_rise;
   wire [7:0]  rx_byte;
   wire [7:0]  sr1_val;
   wire [7:0]  sr2_val;
   wire [7:0]  sr3_val;
   wire [7:0]  sr3_nv;
   wire [2:0]  wr_sel;
   wire        buf_valid;
   wire [7:0]  buf_data;
   wire        buf_pop;
   wire        mem_push;
   wire        load_byte;
   wire        frame_whole;
   assign sclk_rise = spi_clk_i & ~sclk_q & ~cs_n_i;
   assign sclk_fall = ~spi_clk_i & sclk_q & ~cs_n_i;
   assign cs_rise   = cs_n_i & ~cs_q;
   assign rx_byte   = {sh_in[6:0], serial_in_i};
   assign frame_whole = (bit_cnt == 3'h0);
   assign load_byte = sclk_fall & (ocnt == 3'h0)
                    & ((state == ST_OUT) | (state == ST_RDAT));
   assign buf_pop   = load_byte & (state == ST_RDAT);
   assign mem_push  = mem_valid_i & mem_req_o;
   assign wr_sel    = (opcode == `SFC_OP_WRSR2) ? 3'h2
                    : (opcode == `SFC_OP_WRSR3) ? 3'h4
                    : (byte_cnt == 3'h2) ? 3'h3 : 3'h1;
   ////////////////////////////////////////////////////////////////////
   sfc_stat_byte #(
      .WR_MASK  (`SFC_SR1_WR_MASK),
      .OTP_MASK (`SFC_SR1_OTP_MASK),
      .NV_INIT  (`SFC_SR1_INIT)
   ) u_sr1 (
      .sys_clk_i (sys_clk_i),
      .nrst_i    (nrst_i),
      .reload_i  (hw_reset_i),
      .wr_vol_i  (commit_vol[0]),
      .wr_nv_i   (commit_nv[0]),
      .data_i    (p1),
      .value_o   (sr1_val),
      .stored_o  ()
   );
   sfc_stat_byte #(
      .WR_MASK  (`SFC_SR2_WR_MASK),
      .OTP_MASK (`SFC_SR2_OTP_MASK),
      .NV_INIT  (`SFC_SR2_INIT)
   ) u_sr2 (
      .sys_clk_i (sys_clk_i),
      .nrst_i    (nrst_i),
      .reload_i  (hw_reset_i),
      .wr_vol_i  (commit_vol[1]),
      .wr_nv_i   (commit_nv[1]),
      .data_i    (p2),
      .value_o   (sr2_val),
      .stored_o  ()
   );
   sfc_stat_byte #(
      .WR_MASK  (`SFC_SR3_WR_MASK),
      .OTP_MASK (`SFC_SR3_OTP_MASK),
      .NV_INIT  (`SFC_SR3_INIT)
   ) u_sr3 (
      .sys_clk_i (sys_clk_i),
      .nrst_i    (nrst_i),
      .reload_i  (hw_reset_i),
      .wr_vol_i  (commit_vol[2]),
      .wr_nv_i   (commit_nv[2]),
      .data_i    (p1),
      .value_o   (sr3_val),
      .stored_o  (sr3_nv)
   );
   sfc_buf2 #(
      .WIDTH (8)
   ) u_buf (
      .sys_clk_i   (sys_clk_i),
      .nrst_i      (nrst_i),
      .flush_i     (cs_rise),
      .in_valid_i  (mem_push),
      .in_ready_o  (mem_ready_o),
      .in_data_i   (mem_data_i),
      .out_valid_o (buf_valid),
      .out_ready_i (buf_pop),
      .out_data_o  (buf_data)
   );
   ////////////////////////////////////////////////////////////////////
   // byte presented at the start of each outgoing byte
   always @* begin
      out_byte = 8'h00;
      if (state == ST_RDAT) begin
         // empty buffer sends zeros; memory must keep ahead of the link
         out_byte = buf_valid ? buf_data : 8'h00;
      end else if (opcode == `SFC_OP_RDSR1) begin
         out_byte = {sr1_val[7:2], write_enable_latch_o, busy_o};
      end else if (opcode == `SFC_OP_RDSR2) begin
         out_byte = sr2_val;
      end else if (opcode == `SFC_OP_RDSR3) begin
         out_byte = {sr3_val[7:1], addr_width_state_o};
      end else if (opcode == `SFC_OP_RDEAR) begin
         out_byte = upper_address_byte_o;
      end
   end
   ////////////////////////////////////////////////////////////////////
   // serial output on falling clock edges
   always @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         serial_out_o      <= 1'b0;
         serial_out_oe_n_o <= 1'b1;
         osh               <= 8'h00;
         ocnt              <= 3'h0;
      end else if (cs_n_i) begin
         serial_out_oe_n_o <= 1'b1;
         ocnt              <= 3'h0;
      end else if (load_byte) begin
         // status re-sampled per byte so busy polling sees live value
         serial_out_o      <= out_byte[7];
         osh               <= {out_byte[6:0], 1'b0};
         ocnt              <= 3'h1;
         serial_out_oe_n_o <= 1'b0;
      end else if (sclk_fall & (ocnt != 3'h0)) begin
         serial_out_o <= osh[7];
         osh          <= {osh[6:0], 1'b0};
         ocnt         <= ocnt + 3'h1;
      end
   end
   ////////////////////////////////////////////////////////////////////
   // memory address counter, advances on every accepted byte
   always @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         mem_addr_o <= 32'h0000_0000;
      end else if (sclk_rise & (state == ST_ADDR) & ~busy_o
                   & (byte_cnt == (addr_width_state_o ? `SFC_ADDR4_LAST
                                                      : `SFC_ADDR3_LAST)))
      begin
         if (addr_width_state_o) begin
            mem_addr_o <= {addr_lo, rx_byte};
         end else begin
            mem_addr_o <= {upper_address_byte_o, addr_lo[15:0],
                           rx_byte};
         end
      end else if (mem_push & mem_ready_o) begin
         mem_addr_o <= mem_addr_o + 32'h0000_0001;
      end
   end
   ////////////////////////////////////////////////////////////////////
   // command decode and control state
   always @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state                <= ST_OPC;
         sclk_q               <= 1'b0;
         cs_q                 <= 1'b1;
         sh_in                <= 8'h00;
         bit_cnt              <= 3'h0;
         byte_cnt             <= 3'h0;
         opcode               <= 8'h00;
         addr_lo              <= 24'h00_0000;
         wd1                  <= 8'h00;
         wd2                  <= 8'h00;
         vol_armed            <= 1'b0;
         tw_cnt               <= 16'h0000;
         p1                   <= 8'h00;
         p2                   <= 8'h00;
         pend_sel             <= 3'h0;
         commit_vol           <= 3'h0;
         commit_nv            <= 3'h0;
         mem_req_o            <= 1'b0;
         write_enable_latch_o <= 1'b0;
         busy_o               <= 1'b0;
         addr_width_state_o   <= SR3_INIT[`SFC_SR3_ADP_BIT];
         upper_address_byte_o <= `SFC_EXT_INIT;
      end else begin
         sclk_q     <= spi_clk_i;
         cs_q       <= cs_n_i;
         commit_vol <= 3'h0;
         commit_nv  <= 3'h0;
         if (hw_reset_i) begin
            write_enable_latch_o <= 1'b0;
            upper_address_byte_o <= `SFC_EXT_INIT;
            addr_width_state_o   <= sr3_nv[`SFC_SR3_ADP_BIT];
            busy_o               <= 1'b0;
            vol_armed            <= 1'b0;
         end else if (busy_o) begin
            if (tw_cnt == 16'h0000) begin
               busy_o               <= 1'b0;
               write_enable_latch_o <= 1'b0;
               commit_nv            <= pend_sel;
            end else begin
               tw_cnt <= tw_cnt - 16'h0001;
            end
         end
         if (cs_n_i | hw_reset_i) begin
            bit_cnt  <= 3'h0;
            byte_cnt <= 3'h0;
            state    <= ST_OPC;
            mem_req_o <= 1'b0;
         end
         if (cs_rise & frame_whole & ~hw_reset_i) begin
            if (state == ST_DONE) begin
               if (opcode == `SFC_OP_WREN) begin
                  write_enable_latch_o <= 1'b1;
               end else if (opcode == `SFC_OP_WRDI) begin
                  write_enable_latch_o <= 1'b0;
               end else if (opcode == `SFC_OP_VWREN) begin
                  vol_armed <= 1'b1;
               end else if (opcode == `SFC_OP_EN4B) begin
                  addr_width_state_o <= 1'b1;
               end else if (opcode == `SFC_OP_EX4B) begin
                  addr_width_state_o <= 1'b0;
               end
            end else if ((state == ST_WDAT) & (byte_cnt != 3'h0)) begin
               if (opcode == `SFC_OP_WREAR) begin
                  if (write_enable_latch_o) begin
                     upper_address_byte_o <= wd1;
                  end
               end else if (vol_armed | write_enable_latch_o) begin
                  vol_armed <= 1'b0;
                  p1 <= wd1;
                  p2 <= (opcode == `SFC_OP_WRSR1) ? wd2 : wd1;
                  pend_sel <= wr_sel;
                  if (vol_armed) begin
                     // volatile path: applied at once, busy and latch untouched
                     commit_vol <= wr_sel;
                  end else begin
                     busy_o <= 1'b1;
                     tw_cnt <= TW_CYCLES[15:0];
                  end
               end
            end
         end else if (sclk_rise) begin
            sh_in   <= rx_byte;
            bit_cnt <= bit_cnt + 3'h1;
            if (bit_cnt == `SFC_LAST_BIT) begin
               case (state)
                  ST_OPC: begin
                     opcode <= rx_byte;
                     if ((rx_byte == `SFC_OP_RDSR1) |
                         (rx_byte == `SFC_OP_RDSR2) |
                         (rx_byte == `SFC_OP_RDSR3)) begin
                        state <= ST_OUT;
                     end else if (busy_o) begin
                        state <= ST_IGN;
                     end else if (rx_byte == `SFC_OP_RDEAR) begin
                        state <= ST_OUT;
                     end else if (rx_byte == `SFC_OP_READ) begin
                        state <= ST_ADDR;
                     end else if ((rx_byte == `SFC_OP_WRSR1) |
                                  (rx_byte == `SFC_OP_WRSR2) |
                                  (rx_byte == `SFC_OP_WRSR3) |
                                  (rx_byte == `SFC_OP_WREAR)) begin
                        state <= ST_WDAT;
                     end else begin
                        state <= ST_DONE;
                     end
                  end
                  ST_ADDR: begin
                     addr_lo  <= {addr_lo[15:0], rx_byte};
                     byte_cnt <= byte_cnt + 3'h1;
                     if (byte_cnt == (addr_width_state_o ? `SFC_ADDR4_LAST
                                                         : `SFC_ADDR3_LAST))
                     begin
                        state     <= ST_RDAT;
                        mem_req_o <= 1'b1;
                        if (addr_width_state_o) begin
                           upper_address_byte_o <= addr_lo[23:16];
                        end
                     end
                  end
                  ST_WDAT: begin
                     byte_cnt <= byte_cnt + 3'h1;
                     if (byte_cnt == 3'h0) begin
                        wd1 <= rx_byte;
                     end else if ((byte_cnt == 3'h1) &
                                  (opcode == `SFC_OP_WRSR1)) begin
                        wd2 <= rx_byte;
                     end else begin
                        state <= ST_IGN;
                     end
                  end
                  ST_DONE: state <= ST_IGN;
                  default: state <= state;
               endcase
            end
         end
      end
   end
endmodule // sfc_frontend

// *** sim/sfc_checker.sv ***
// port assertions for the serial flash command front end
`timescale 1ns/10ps
module sfc_checker (
   input wire        sys_clk_i,
   input wire        nrst_i,
   input wire        hw_reset_i,
   input wire        cs_n_i,
   input wire        serial_out_oe_n_o,
   input wire        mem_req_o,
   input wire [31:0] mem_addr_o,
   input wire        mem_valid_i,
   input wire        mem_ready_o,
   input wire        write_enable_latch_o,
   input wire        busy_o,
   input wire        addr_width_state_o,
   input wire [7:0]  upper_address_byte_o
);
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!nrst_i);
   ////////////////////////////////////////////////////////////////////////
   property p_wel_set;
      $rose(write_enable_latch_o) |-> $past(cs_n_i) && !$past(cs_n_i, 2);
   endproperty
   a_wel_set: assert property (p_wel_set)
      else $error("latch set away from frame end");
   property p_busy_end;
      $fell(busy_o) |-> !write_enable_latch_o;
   endproperty
   a_busy_end: assert property (p_busy_end)
      else $error("latch still set after write cycle");
   property p_busy_start;
      $rose(busy_o) |-> $past(cs_n_i) && $past(write_enable_latch_o);
   endproperty
   a_busy_start: assert property (p_busy_start)
      else $error("write cycle started without latch");
   property p_hw_rst;
      hw_reset_i |=> !write_enable_latch_o && !busy_o
         && upper_address_byte_o == 8'h00;
   endproperty
   a_hw_rst: assert property (p_hw_rst)
      else $error("reset left state behind");
   property p_ear;
      $changed(upper_address_byte_o) |-> $past(hw_reset_i)
         || addr_width_state_o
         || ($past(cs_n_i) && $past(write_enable_latch_o));
   endproperty
   a_ear: assert property (p_ear)
      else $error("upper byte changed without latch");
   property p_rd_busy;
      $rose(mem_req_o) |-> !busy_o;
   endproperty
   a_rd_busy: assert property (p_rd_busy)
      else $error("read started while busy");
   property p_req_end;
      cs_n_i |=> !mem_req_o;
   endproperty
   a_req_end: assert property (p_req_end)
      else $error("read stream outlived the frame");
   property p_oe;
      cs_n_i [*2] |-> serial_out_oe_n_o;
   endproperty
   a_oe: assert property (p_oe)
      else $error("output driven while deselected");
   property p_inc;
      mem_req_o && mem_valid_i && mem_ready_o && !cs_n_i
         |=> mem_addr_o == $past(mem_addr_o) + 32'h1;
   endproperty
   a_inc: assert property (p_inc)
      else $error("address did not advance");
   property p_ads;
      $changed(addr_width_state_o) |-> $past(cs_n_i) || $past(hw_reset_i);
   endproperty
   a_ads: assert property (p_ads)
      else $error("address mode changed mid frame");
   c_nv: cover property ($rose(busy_o));
   c_read: cover property ($rose(mem_req_o));
   c_full: cover property (mem_req_o && !mem_ready_o);
endmodule // sfc_checker

bind sfc_frontend sfc_checker u_sfc_checker (.sys_clk_i, .nrst_i,
   .hw_reset_i, .cs_n_i, .serial_out_oe_n_o, .mem_req_o, .mem_addr_o,
   .mem_valid_i, .mem_ready_o, .write_enable_latch_o, .busy_o,
   .addr_width_state_o, .upper_address_byte_o);

// *** sim/sfc_mem_model.sv ***
// memory array model behind the read stream
`timescale 1ns/10ps
module sfc_mem_model (
   input  wire        sys_clk_i,
   input  wire        nrst_i,
   input  wire        req_i,
   input  wire [31:0] addr_i,
   input  wire        ready_i,
   output wire [7:0]  data_o,
   output wire        valid_o
);
   reg        gap;
   wire [7:0] word = addr_i[7:0] ^ addr_i[31:24];
   assign valid_o = req_i && !gap;
   // inverted when idle so stale bytes never look fresh
   assign data_o = valid_o ? word : ~word;
   // one idle cycle after each byte: a slow answer
   always @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i)
         gap <= 1'b0;
      else
         gap <= valid_o && ready_i;
   end
endmodule // sfc_mem_model

// *** sim/serial_flash_cmd_frontend_tb_top.sv ***
// testbench: host spi command sequences against the front end
`timescale 1ns/10ps
module serial_flash_cmd_frontend_tb_top;
   reg         clk, nrst, hwr, cs_n, sck, din;
   wire        dout, req, rdy, vld, write_enable_latch, busy, addr_width_state, oe;
   wire [31:0] addr;
   wire [7:0]  mdat, ear;
   reg  [7:0]  r;
   integer     num_errors, checked, cyc, i;
   ////////////////////////////////////////////////////////////////////////
   sfc_frontend #(.TW_CYCLES(200)) u_sfc_frontend (.sys_clk_i(clk),
      .nrst_i(nrst), .hw_reset_i(hwr), .cs_n_i(cs_n), .spi_clk_i(sck),
      .serial_in_i(din), .serial_out_o(dout), .serial_out_oe_n_o(oe),
      .mem_req_o(req), .mem_addr_o(addr), .mem_data_i(mdat),
      .mem_valid_i(vld), .mem_ready_o(rdy), .write_enable_latch_o(write_enable_latch),
      .busy_o(busy), .addr_width_state_o(addr_width_state),
      .upper_address_byte_o(ear));
   sfc_mem_model u_sfc_mem_model (.sys_clk_i(clk), .nrst_i(nrst),
      .req_i(req), .addr_i(addr), .ready_i(rdy), .data_o(mdat),
      .valid_o(vld));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////////////
   task tally_and_finish;
      begin
         $display("checked %0d errors %0d", checked, num_errors);
         if (num_errors == 0 && checked > 0)
            $display("SIMULATION PASSED");
         else
            $display("SIMULATION FAILED");
         $finish;
      end
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         num_errors = num_errors + 1;
         tally_and_finish;
      end
   end
   task chk(input [8*4:1] nm, input [31:0] e, input [31:0] g);
      begin
         checked = checked + 1;
         if (g !== e) begin
            num_errors = num_errors + 1;
            $display("[FAIL] %0s exp %h got %h", nm, e, g);
         end
      end
   endtask
   // mode 0, two system cycles per phase
   task bits(input [7:0] tx, input integer n, output [7:0] rx);
      integer b;
      begin
         for (b = 0; b < n; b = b + 1) begin
            din = tx[7-b];
            repeat (2) @(negedge clk);
            rx[7-b] = dout;
            sck = 1'b1;
            repeat (2) @(negedge clk);
            sck = 1'b0;
         end
      end
   endtask
   task cs_lo;
      begin
         cs_n = 1'b0;
         repeat (2) @(negedge clk);
      end
   endtask
   task cs_hi;
      begin
         cs_n = 1'b1;
         repeat (4) @(negedge clk);
      end
   endtask
   task frame(input [39:0] bs, input integer n, input keep);
      integer k;
      begin
         cs_lo;
         for (k = 0; k < n; k = k + 1)
            bits(bs[8*n-1-8*k -: 8], 8, r);
         if (!keep)
            cs_hi;
      end
   endtask
   task rd(input [8*4:1] nm, input [7:0] e, input [7:0] op);
      begin
         frame(op, 1, 1);
         bits(8'h00, 8, r);
         chk(nm, e, r);
         bits(8'h00, 8, r);
         chk(nm, e, r);
         chk("oe", 0, oe);
         cs_hi;
         chk("oe", 1, oe);
      end
   endtask
   task wait_idle;
      begin
         for (i = 0; i < 300 && busy === 1'b1; i = i + 1)
            @(negedge clk);
         chk("busy", 0, busy);
      end
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      nrst = 1'b0;
      hwr = 1'b0;
      cs_n = 1'b1;
      sck = 1'b0;
      din = 1'b0;
      num_errors = 0;
      checked = 0;
      cyc = 0;
      repeat (6) @(negedge clk);
      nrst = 1'b1;
      repeat (2) @(negedge clk);
      rd("sr1", 8'h00, 8'h05);
      rd("ear", 8'h00, 8'hC8);
      frame(8'h06, 1, 0);
      rd("sr1", 8'h02, 8'h05);
      frame(8'h04, 1, 0);
      chk("wel", 0, write_enable_latch);
      cs_lo;
      bits(8'h06, 5, r);
      cs_hi;
      chk("wel", 0, write_enable_latch);
      frame(8'h50, 1, 0);
      chk("wel", 0, write_enable_latch);
      frame(16'h31FF, 2, 0);
      chk("busy", 0, busy);
      rd("sr2", 8'h7B, 8'h35);
      frame(8'h50, 1, 0);
      frame(16'h3100, 2, 0);
      rd("sr2", 8'h39, 8'h35);
      hwr = 1'b1;
      @(negedge clk);
      hwr = 1'b0;
      repeat (2) @(negedge clk);
      rd("sr2", 8'h00, 8'h35);
      frame(8'h06, 1, 0);
      frame(24'h01FFFF, 3, 0);
      rd("sr1", 8'h03, 8'h05);
      frame(32'h03000000, 4, 1);
      chk("req", 0, req);
      cs_hi;
      wait_idle;
      rd("sr1", 8'h7C, 8'h05);
      rd("sr2", 8'h7B, 8'h35);
      frame(8'h06, 1, 0);
      frame(16'h0100, 2, 0);
      wait_idle;
      rd("sr1", 8'h00, 8'h05);
      rd("sr2", 8'h7B, 8'h35);
      frame(16'hC55A, 2, 0);
      rd("ear", 8'h00, 8'hC8);
      frame(8'h06, 1, 0);
      frame(16'hC55A, 2, 0);
      rd("ear", 8'h5A, 8'hC8);
      frame(32'h03123456, 4, 1);
      for (i = 0; i < 3; i = i + 1) begin
         bits(8'h00, 8, r);
         chk("data", 8'h5A ^ (8'h56 + i[7:0]), r);
      end
      cs_hi;
      frame(8'hB7, 1, 0);
      chk("ads", 1, addr_width_state);
      frame(40'h0301020304, 5, 1);
      bits(8'h00, 8, r);
      chk("data", 8'h05, r);
      cs_hi;
      chk("ear", 8'h01, ear);
      frame(8'hE9, 1, 0);
      chk("ads", 0, addr_width_state);
      frame(8'h50, 1, 0);
      frame(16'h11FF, 2, 0);
      rd("sr3", 8'h66, 8'h15);
      tally_and_finish;
   end
endmodule // serial_flash_cmd_frontend_tb_top
